//--- bench/dspwm_assertions.sv
// concurrent checks on the pwm top ports
`include "dspwm_defines.svh"
module dspwm_assertions #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic channel0_pin_out,
	input wire logic channel0_pin_oe,
	input wire logic channel1_pin_out,
	input wire logic channel1_pin_oe
);
	logic [7:0] ctrl_r, port_r, pos_r;
	logic wr, mapped;
	assign wr = psel & penable & pwrite & pstrb[0] & pready;
	assign mapped = paddr inside {`DSPWM_OFF_CTRL, `DSPWM_OFF_DUTY0, `DSPWM_OFF_DUTY1, `DSPWM_OFF_PORT, `DSPWM_OFF_STAT};
	// mirror of control and port bits, plus clocks since reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 8'h00;
			port_r <= 8'h30;
			pos_r <= 8'h00;
		end else begin
			pos_r <= pos_r + 8'h01;
			if (wr && paddr == `DSPWM_OFF_CTRL) ctrl_r <= pwdata[7:0];
			if (wr && paddr == `DSPWM_OFF_PORT) port_r <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_OE0: assert property (channel0_pin_oe == !port_r[4]) else $error("pin 0 drive enable wrong");
	AST_OE1: assert property (channel1_pin_oe == !port_r[5]) else $error("pin 1 drive enable wrong");
	AST_LOW0: assert property (ctrl_r[5] && !port_r[0] |-> !channel0_pin_out) else $error("pin 0 not held low");
	AST_LOW1: assert property (ctrl_r[6] && !port_r[1] |-> !channel1_pin_out) else $error("pin 1 not held low");
	AST_PASS0: assert property (!ctrl_r[5] |-> channel0_pin_out == port_r[0]) else $error("pin 0 lost port data");
	AST_PASS1: assert property (!ctrl_r[6] |-> channel1_pin_out == port_r[1]) else $error("pin 1 lost port data");
	// a pulse may only begin on a sub-cycle's first clock; wave lags count by one
	AST_RISE0: assert property (
		$rose(channel0_pin_out) && ctrl_r[5] && port_r[0] && $past(port_r[0]) |->
		pos_r[5:0] == 6'h01) else $error("pin 0 rose inside a sub-cycle");
	AST_RISE1: assert property (
		$rose(channel1_pin_out) && ctrl_r[6] && port_r[1] && $past(port_r[1]) |->
		pos_r[5:0] == 6'h01) else $error("pin 1 rose inside a sub-cycle");
	AST_READY: assert property (psel && penable |-> pready) else $error("access phase not answered");
	AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped) else $error("error response wrong");
	cover property ($rose(channel0_pin_out) && ctrl_r[7]);
	cover property ($rose(channel1_pin_out) && !ctrl_r[7]);
	cover property (psel && penable && pslverr);
endmodule // dspwm_assertions
bind dspwm_top dspwm_assertions #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.pslverr(pslverr), .channel0_pin_out(channel0_pin_out), .channel0_pin_oe(channel0_pin_oe),
	.channel1_pin_out(channel1_pin_out), .channel1_pin_oe(channel1_pin_oe));

//--- bench/dspwm_load.sv
// external load model on the two shared pins
module dspwm_load (
	// pin drive from the block
	input wire logic [1:0] out,
	input wire logic [1:0] oe,
	// level seen back at the pins
	output logic [1:0] lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	// released pin floats up through the pull-high, never holds the old level
	assign lvl = (out & oe) | ~oe;
endmodule // dspwm_load

//--- bench/tb_top.sv
// self-checking bench for the dual-channel pwm
`include "dspwm_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, rel_r, ctrl_s, port_s;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] p_out, p_oe, p_lvl;
	int n_fail, cmp_count;
	logic [7:0] dl [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'h81, 8'h7F, 8'hFF};
	dspwm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.channel0_pin_in(p_lvl[0]), .channel0_pin_out(p_out[0]), .channel0_pin_oe(p_oe[0]),
		.channel1_pin_in(p_lvl[1]), .channel1_pin_out(p_out[1]), .channel1_pin_oe(p_oe[1]));
	dspwm_load i_load (.out(p_out), .oe(p_oe), .lvl(p_lvl));
	// ----------------------------------------
	// clock, reset position and helpers
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// clocks since release; the pin shows count minus one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) rel_r <= 8'h00;
		else rel_r <= rel_r + 8'h01;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h000000, d});
		if (a == `DSPWM_OFF_CTRL) ctrl_s = d;
		if (a == `DSPWM_OFF_PORT) port_s = d;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(a, 1'b0, 32'h00000000);
		chk(rd, e);
		chk({31'h0, err}, {31'h0, ee});
	endtask
	// expected wave: coarse part plus one in sub-cycles below the remainder
	function automatic logic wv(input logic m, input logic [7:0] d, input logic [7:0] p);
		if (m) return {2'b00, p[5:0]} < ({2'b00, d[7:2]} + 8'(p[7:6] < d[1:0]));
		return {1'b0, p[6:0]} < ({1'b0, d[7:1]} + 8'(p[7] < d[0]));
	endfunction
	task automatic wait_end;
		do @(negedge pclk); while (rel_r != 8'h00);
	endtask
	// check both pins each clock up to the end of the current full cycle
	task automatic run_cycle(input logic [7:0] d0, input logic [7:0] d1);
		logic [7:0] p;
		logic [1:0] w;
		do begin
			@(negedge pclk);
			p = rel_r - 8'h01;
			w = {wv(ctrl_s[7], d1, p), wv(ctrl_s[7], d0, p)};
			chk({30'h0, p_oe}, {30'h0, ~port_s[5:4]});
			chk({30'h0, p_out}, {30'h0, (ctrl_s[6:5] & w & port_s[1:0]) | (~ctrl_s[6:5] & port_s[1:0])});
		end while (p != 8'hFF);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdchk(`DSPWM_OFF_CTRL, 32'h00000000, 1'b0);
		rdchk(`DSPWM_OFF_DUTY1, 32'h00000000, 1'b0);
		rdchk(`DSPWM_OFF_PORT, 32'h00000030, 1'b0);
		rdchk(8'h14, 32'h00000000, 1'b1);
		apb(`DSPWM_OFF_STAT, 1'b0, 32'h00000000);
		chk(rd & 32'h0000000F, 32'h00000003);
	endtask
	task automatic t_duty(input logic m, input logic [7:0] d0, input logic [7:0] d1);
		wait_end;
		wr(`DSPWM_OFF_CTRL, {m, 7'h60});
		wr(`DSPWM_OFF_DUTY0, d0);
		wr(`DSPWM_OFF_DUTY1, d1);
		rdchk(`DSPWM_OFF_DUTY0, {24'h0, d0}, 1'b0);
		wait_end;
		run_cycle(d0, d1);
	endtask
	task automatic t_latch;
		wait_end;
		wr(`DSPWM_OFF_DUTY0, 8'h41);
		wr(`DSPWM_OFF_DUTY1, 8'hC2);
		run_cycle(8'hFF, 8'h00);
		run_cycle(8'h41, 8'hC2);
	endtask
	task automatic t_gate;
		wr(`DSPWM_OFF_PORT, 8'h02);
		run_cycle(8'h41, 8'hC2);
		wr(`DSPWM_OFF_PORT, 8'h12);
		apb(`DSPWM_OFF_STAT, 1'b0, 32'h00000000);
		chk(rd & 32'h00000001, 32'h00000001);
		run_cycle(8'h41, 8'hC2);
		wr(`DSPWM_OFF_CTRL, 8'h80);
		wr(`DSPWM_OFF_PORT, 8'h01);
		run_cycle(8'h41, 8'hC2);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// hang guard: about twice the expected run
	initial begin
		#1200000;
		n_fail++;
		final_report();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		ctrl_s = 8'h00;
		port_s = 8'h30;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		// route, make outputs, load duty, then enable data
		wr(`DSPWM_OFF_CTRL, 8'h60);
		wr(`DSPWM_OFF_PORT, 8'h00);
		wr(`DSPWM_OFF_DUTY0, 8'h10);
		wr(`DSPWM_OFF_PORT, 8'h03);
		for (int m = 0; m < 2; m++) begin
			foreach (dl[i]) t_duty(m[0], dl[i], ~dl[i]);
		end
		t_latch();
		t_gate();
		final_report();
	end
endmodule // tb_top

//--- verilog/dspwm_chan_if.sv
// link between the register block and one modulator channel
interface dspwm_chan_if;
	logic [7:0] duty;
	dspwm_pkg::dspwm_mode_e mode;
	logic wave;
	logic start;
	logic [1:0] sub_idx;

	modport ctrl (output duty, output mode, input wave, input start, input sub_idx);
	modport chan (input duty, input mode, output wave, output start, output sub_idx);
endinterface

//--- verilog/dspwm_channel.sv
// one 8-bit modulator channel with sub-cycle spreading
`include "dspwm_defines.svh"

module dspwm_channel #(
	parameter int DUTY_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// settings in, waveform out
	dspwm_chan_if.chan ch
);

	// the counter and split logic assume an 8-bit duty word
	if (DUTY_W != 8) begin : g_bad_width
		$error("dspwm_channel: only an 8-bit duty word is supported");
	end

	dspwm_pkg::dspwm_chan_s s_r;
	dspwm_pkg::dspwm_chan_s s_nxt;

	// high time of the current sub-cycle: coarse part plus one while index below remainder
	function automatic logic [7:0] on_clks(input logic [7:0] duty, input dspwm_pkg::dspwm_mode_e mode,
		input logic [1:0] sub);
		logic [7:0] coarse;
		logic ext;
		coarse = 8'h00;
		ext = 1'b0;
		if (mode == dspwm_pkg::DSPWM_MODE_SUB4) begin
			coarse = {2'b00, duty[7:2]};
			ext = (sub < duty[1:0]);
		end else begin
			coarse = {1'b0, duty[7:1]};
			ext = (sub[0] < duty[0]);
		end
		return coarse + {7'h00, ext};
	endfunction

	// next-state logic
	always_comb begin
		s_nxt = s_r;
		// [RULE_02] free counter
		s_nxt.cnt = s_r.cnt + 8'h01;
		// [RULE_05] [RULE_08] sub-cycle index
		if (s_r.mode_act == dspwm_pkg::DSPWM_MODE_SUB4) begin
			s_nxt.sub_idx = s_r.cnt[7:6];
			// [RULE_06] [RULE_07] [RULE_14] high from sub-cycle start
			s_nxt.wave = {2'b00, s_r.cnt[5:0]} < on_clks(s_r.duty_act, s_r.mode_act, s_r.cnt[7:6]);
		end else begin
			s_nxt.sub_idx = {1'b0, s_r.cnt[7]};
			// [RULE_09] [RULE_10] [RULE_14] high from sub-cycle start
			s_nxt.wave = {1'b0, s_r.cnt[6:0]} < on_clks(s_r.duty_act, s_r.mode_act, {1'b0, s_r.cnt[7]});
		end
		s_nxt.start = (s_r.cnt == 8'h00);
		// [RULE_15] take new settings only at cycle end
		if (s_r.cnt == 8'(`DSPWM_CYCLE_CLKS - 1)) begin
			s_nxt.duty_act = ch.duty;
			s_nxt.mode_act = ch.mode;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{cnt: 8'h00, duty_act: `DSPWM_RST_DUTY, mode_act: dspwm_pkg::DSPWM_MODE_SUB2,
				wave: 1'b0, start: 1'b0, sub_idx: 2'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ch.wave = s_r.wave;
	assign ch.start = s_r.start;
	assign ch.sub_idx = s_r.sub_idx;

endmodule // dspwm_channel

//--- verilog/dspwm_defines.svh
// constants for the dual-channel subdivided pwm block
`ifndef DSPWM_DEFINES_SVH
`define DSPWM_DEFINES_SVH

// register byte offsets
`define DSPWM_OFF_CTRL 8'h00
`define DSPWM_OFF_DUTY0 8'h04
`define DSPWM_OFF_DUTY1 8'h08
`define DSPWM_OFF_PORT 8'h0C
`define DSPWM_OFF_STAT 8'h10

// modulator_control fields
`define DSPWM_CTRL_MODE_BIT 7
`define DSPWM_CTRL_ROUTE1_BIT 6
`define DSPWM_CTRL_ROUTE0_BIT 5

// port_pin_control fields (data and direction, direction 1 = input)
`define DSPWM_PORT_DATA0_BIT 0
`define DSPWM_PORT_DATA1_BIT 1
`define DSPWM_PORT_DIR0_BIT 4
`define DSPWM_PORT_DIR1_BIT 5

// status fields
`define DSPWM_STAT_PIN0_BIT 0
`define DSPWM_STAT_PIN1_BIT 1
`define DSPWM_STAT_WAVE0_BIT 2
`define DSPWM_STAT_WAVE1_BIT 3
`define DSPWM_STAT_SUB0_LSB 8
`define DSPWM_STAT_SUB1_LSB 10

// reset values
`define DSPWM_RST_CTRL 8'h00
`define DSPWM_RST_DUTY 8'h00
`define DSPWM_RST_PORT 8'h30

// timing counts in system clocks
`define DSPWM_CYCLE_CLKS 256
`define DSPWM_SUB4_CLKS 64
`define DSPWM_SUB2_CLKS 128

`endif

//--- verilog/dspwm_pin_ctl.sv
// shared pin steering for one channel
module dspwm_pin_ctl (
	// selection and port bits
	input wire logic route,
	input wire logic dir_in,
	input wire logic port_data,
	// waveform from the modulator
	input wire logic wave,
	// pin drive
	output logic pin_out,
	output logic pin_oe
);

	// pin driver select
	always_comb begin
		// [RULE_13] direction input wins over routing
		pin_oe = !dir_in;
		if (route) begin
			// [RULE_04] [RULE_12] data bit gates the waveform
			pin_out = wave & port_data;
		end else begin
			// [RULE_04] other shared function: plain output
			pin_out = port_data;
		end
	end

endmodule // dspwm_pin_ctl

//--- verilog/dspwm_pkg.sv
// types shared by the pwm block
package dspwm_pkg;

	// sub-division mode, matches the control bit value
	typedef enum logic {
		DSPWM_MODE_SUB2,
		DSPWM_MODE_SUB4
	} dspwm_mode_e;

	// state of one modulator channel
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] duty_act;
		dspwm_mode_e mode_act;
		logic wave;
		logic start;
		logic [1:0] sub_idx;
	} dspwm_chan_s;

	// state of the register block
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] duty0;
		logic [7:0] duty1;
		logic [7:0] port;
		logic [31:0] rdata;
		logic err;
	} dspwm_regs_s;

endpackage

//--- verilog/dspwm_top.sv
// dual-channel subdivided pwm with apb register access
//
// Notes on behaviour
// [RULE_01] two independent channels, each with own 8-bit duty register and pin
// [RULE_02] each modulator counts system clocks; full cycle is 256 clocks
// [RULE_03] control bit 7 picks mode for both: 0 two sub-cycles, 1 four
// [RULE_04] control bits 6 and 5 route channels 1 and 0 onto their pins
// [RULE_05] four-sub-cycle mode: sub-cycles 0 to 3 of 64 clocks each
// [RULE_06] four-sub-cycle mode: coarse is duty bits 7..2, remainder bits 1..0
// [RULE_07] sub-cycle i high coarse+1 clocks if i below remainder, else coarse
// [RULE_08] two-sub-cycle mode: sub-cycles 0 and 1 of 128 clocks each
// [RULE_09] two-sub-cycle mode: coarse is duty bits 7..1, remainder bit 0
// [RULE_10] sub-cycle i high coarse+1 clocks if i below remainder bit, else coarse
// [RULE_11] software routes, sets pin as output, loads duty, then sets data bit
// [RULE_12] routed pin: data bit zero forces low, one passes the waveform
// [RULE_13] routed pin set as input behaves as an ordinary input
// [RULE_14] each sub-cycle starts high for the computed count, then low
// [RULE_15] new duty takes effect only at the next full cycle start
`include "dspwm_defines.svh"

module dspwm_top #(
	parameter int ADDR_W = 8,
	parameter int DUTY_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel 0 pin
	input wire logic channel0_pin_in,
	output logic channel0_pin_out,
	output logic channel0_pin_oe,
	// channel 1 pin
	input wire logic channel1_pin_in,
	output logic channel1_pin_out,
	output logic channel1_pin_oe
);

	//--------------------------------------------------------------------
	// elaboration checks
	//--------------------------------------------------------------------

	// decode needs the top offset to fit; register layout needs 8-bit duty
	if (ADDR_W < 8) begin : g_bad_addr
		$error("dspwm_top: address bus narrower than the register map");
	end
	if (DUTY_W != 8) begin : g_bad_duty
		$error("dspwm_top: only an 8-bit duty word is supported");
	end

	//--------------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------------

	dspwm_pkg::dspwm_regs_s s_r;
	dspwm_pkg::dspwm_regs_s s_nxt;

	dspwm_chan_if ch0_if ();
	dspwm_chan_if ch1_if ();

	logic setup_ph;
	logic access_ph;
	logic wr_lane0;
	logic [7:0] addr_lo;
	logic addr_hi_zero;
	logic [31:0] stat_word;
	logic route0;
	logic route1;

	//--------------------------------------------------------------------
	// helper functions
	//--------------------------------------------------------------------

	// true when the offset names one of the five words
	function automatic logic reg_hit(input logic [7:0] off);
		logic hit;
		hit = 1'b0;
		case (off)
			`DSPWM_OFF_CTRL: hit = 1'b1;
			`DSPWM_OFF_DUTY0: hit = 1'b1;
			`DSPWM_OFF_DUTY1: hit = 1'b1;
			`DSPWM_OFF_PORT: hit = 1'b1;
			`DSPWM_OFF_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// one byte placed in the low lane, upper bits zero
	function automatic logic [31:0] low_byte(input logic [7:0] b);
		return {24'h000000, b};
	endfunction

	//--------------------------------------------------------------------
	// apb phase decode
	//--------------------------------------------------------------------

	// zero-wait slave: every access phase completes at once
	assign setup_ph = psel & !penable;
	assign access_ph = psel & penable;
	assign pready = 1'b1;
	assign addr_lo = paddr[7:0];
	// only lane 0 carries writable register bits; the rest of a written word is ignored
	assign wr_lane0 = access_ph & pwrite & pstrb[0] & addr_hi_zero;

	// upper address bits must be zero for a hit
	always_comb begin
		addr_hi_zero = 1'b1;
		for (int i = 8; i < ADDR_W; i++) begin
			if (paddr[i]) begin
				addr_hi_zero = 1'b0;
			end
		end
	end

	//--------------------------------------------------------------------
	// status word
	//--------------------------------------------------------------------

	// pin levels, live waveforms and sub-cycle indices, for polling
	always_comb begin
		stat_word = 32'h00000000;
		// [RULE_13] input pin level stays readable
		stat_word[`DSPWM_STAT_PIN0_BIT] = channel0_pin_in;
		stat_word[`DSPWM_STAT_PIN1_BIT] = channel1_pin_in;
		stat_word[`DSPWM_STAT_WAVE0_BIT] = ch0_if.wave;
		stat_word[`DSPWM_STAT_WAVE1_BIT] = ch1_if.wave;
		stat_word[`DSPWM_STAT_SUB0_LSB +: 2] = ch0_if.sub_idx;
		stat_word[`DSPWM_STAT_SUB1_LSB +: 2] = ch1_if.sub_idx;
	end

	//--------------------------------------------------------------------
	// register next state
	//--------------------------------------------------------------------

	// writes land at the access edge; read data is caught at the setup edge
	// so prdata comes from a flop while the slave still needs no wait state
	always_comb begin
		s_nxt = s_r;
		if (setup_ph) begin
			s_nxt.err = !(addr_hi_zero && reg_hit(addr_lo));
			s_nxt.rdata = 32'h00000000;
			if (!pwrite && addr_hi_zero) begin
				case (addr_lo)
					// buzzer field bits 4..0 are not kept and read zero
					`DSPWM_OFF_CTRL: s_nxt.rdata = low_byte({s_r.ctrl[7:5], 5'h00});
					`DSPWM_OFF_DUTY0: s_nxt.rdata = low_byte(s_r.duty0);
					`DSPWM_OFF_DUTY1: s_nxt.rdata = low_byte(s_r.duty1);
					`DSPWM_OFF_PORT: s_nxt.rdata = low_byte(s_r.port);
					`DSPWM_OFF_STAT: s_nxt.rdata = stat_word;
					default: s_nxt.rdata = 32'h00000000;
				endcase
			end
		end
		if (wr_lane0) begin
			case (addr_lo)
				// [RULE_03] [RULE_04] mode and routing bits
				`DSPWM_OFF_CTRL: s_nxt.ctrl = {pwdata[7:5], 5'h00};
				// [RULE_01] separate duty word per channel
				`DSPWM_OFF_DUTY0: s_nxt.duty0 = pwdata[7:0];
				`DSPWM_OFF_DUTY1: s_nxt.duty1 = pwdata[7:0];
				// only data and direction bits exist
				`DSPWM_OFF_PORT: s_nxt.port = pwdata[7:0] & 8'h33;
				default: s_nxt.port = s_r.port;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// register state
	//--------------------------------------------------------------------

	// pins come up as inputs so nothing is driven before software decides
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{ctrl: `DSPWM_RST_CTRL, duty0: `DSPWM_RST_DUTY, duty1: `DSPWM_RST_DUTY,
				port: `DSPWM_RST_PORT, rdata: 32'h00000000, err: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.rdata;
	// error shown only while the access phase is on the bus
	assign pslverr = s_r.err & access_ph;

	//--------------------------------------------------------------------
	// channel settings
	//--------------------------------------------------------------------

	// [RULE_03] one mode bit serves both channels
	assign ch0_if.mode = dspwm_pkg::dspwm_mode_e'(s_r.ctrl[`DSPWM_CTRL_MODE_BIT]);
	assign ch1_if.mode = dspwm_pkg::dspwm_mode_e'(s_r.ctrl[`DSPWM_CTRL_MODE_BIT]);
	assign ch0_if.duty = s_r.duty0;
	assign ch1_if.duty = s_r.duty1;
	assign route0 = s_r.ctrl[`DSPWM_CTRL_ROUTE0_BIT];
	assign route1 = s_r.ctrl[`DSPWM_CTRL_ROUTE1_BIT];

	//--------------------------------------------------------------------
	// modulators
	//--------------------------------------------------------------------

	// [RULE_01] two independent modulators, each with its own counter
	dspwm_channel #(
		.DUTY_W(DUTY_W)
	) u_chan0 (
		.pclk(pclk),
		.presetn(presetn),
		.ch(ch0_if.chan)
	);

	dspwm_channel #(
		.DUTY_W(DUTY_W)
	) u_chan1 (
		.pclk(pclk),
		.presetn(presetn),
		.ch(ch1_if.chan)
	);

	//--------------------------------------------------------------------
	// pin steering
	//--------------------------------------------------------------------

	// [RULE_11] software order is route, direction, duty, data; no sequencing enforced here
	dspwm_pin_ctl u_pin0 (
		.route(route0),
		.dir_in(s_r.port[`DSPWM_PORT_DIR0_BIT]),
		.port_data(s_r.port[`DSPWM_PORT_DATA0_BIT]),
		.wave(ch0_if.wave),
		.pin_out(channel0_pin_out),
		.pin_oe(channel0_pin_oe)
	);

	dspwm_pin_ctl u_pin1 (
		.route(route1),
		.dir_in(s_r.port[`DSPWM_PORT_DIR1_BIT]),
		.port_data(s_r.port[`DSPWM_PORT_DATA1_BIT]),
		.wave(ch1_if.wave),
		.pin_out(channel1_pin_out),
		.pin_oe(channel1_pin_oe)
	);

endmodule // dspwm_top
